/* File: rtl/lmx_alu.sv */
// combinational result path: nibble exchange and exclusive or with zero detect
`include "lmx_map.svh"
module lmx_alu (
	input  wire logic [2:0] op,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] lit,
	input  wire logic [7:0] fval,
	output logic      [7:0] result,
	output logic            zero
);
	// only two ops compute; the rest pass the accumulator through
	always_comb begin
		case (op)
			`LMX_OP_NIBBLE_X: result = {fval[3:0], fval[7:4]};
			`LMX_OP_XOR_LIT:  result = acc ^ lit;
			default:          result = acc;
		endcase
		zero = (result == 8'h00);
	end
endmodule

/* File: rtl/lmx_core.sv */
// literal, move, nibble exchange and xor datapath behind an axi4-lite slave
//
// Summary of operation
// - literal 0..127 loads upper latch, flags unchanged
// - literal 0..255 loads accumulator, one cycle
// - unused operand bits must be zero
// - accumulator copied into addressed file register
// - nibble exchange swaps upper and lower nibbles
// - destination bit picks accumulator or file
// - accumulator xor literal into accumulator, zero updated
`include "lmx_map.svh"
module lmx_core #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [7:0]             acc_out,
	output logic [6:0]             pclatch_out,
	output logic                   zero_out
);
	lmx_pkg::lmx_state_s q;
	lmx_pkg::lmx_state_s d;

	logic       wr_fire;
	logic       rd_fire;
	logic [2:0] cmd_op;
	logic       cmd_dest;
	logic [7:0] cmd_lit;
	logic [6:0] cmd_faddr;
	logic       cmd_ok;
	logic [7:0] alu_result;
	logic       alu_zero;
	logic [7:0] wr_off;
	logic [7:0] rd_off;

	// protection bits carry no meaning here
	logic unused_prot;
	assign unused_prot = ^{awprot, arprot};

	// handshakes complete only on the cycle the registered ready is high
	assign wr_fire = q.awready & awvalid & wvalid;
	assign rd_fire = q.arready & arvalid;

	// offsets compared over the full address width, so aliases answer as unmapped
	assign wr_off = (awaddr[ADDR_W-1:0] == ADDR_W'(awaddr[7:0])) ? awaddr[7:0] : 8'hff;
	assign rd_off = (araddr[ADDR_W-1:0] == ADDR_W'(araddr[7:0])) ? araddr[7:0] : 8'hff;

	// command word fields
	assign cmd_op    = wdata[`LMX_CMD_OP_MSB:`LMX_CMD_OP_LSB];
	assign cmd_dest  = wdata[`LMX_CMD_DEST];
	assign cmd_lit   = wdata[`LMX_CMD_LIT_MSB:`LMX_CMD_LIT_LSB];
	assign cmd_faddr = wdata[`LMX_CMD_LIT_MSB-1:`LMX_CMD_LIT_LSB];

	// encoding check: high bits, the destination bit outside the swap, and bit 7 of
	// a seven-bit operand must all be zero; a word that breaks this never executes
	always_comb begin
		cmd_ok = (wdata[`LMX_CMD_HI_MSB:`LMX_CMD_HI_LSB] == 20'h00000);
		case (cmd_op)
			`LMX_OP_LOAD_UPPER,
			`LMX_OP_STORE_ACC: begin
				cmd_ok = cmd_ok & ~cmd_dest & ~wdata[`LMX_CMD_TOP7];
			end
			`LMX_OP_NIBBLE_X: begin
				cmd_ok = cmd_ok & ~wdata[`LMX_CMD_TOP7];
			end
			`LMX_OP_LOAD_ACC,
			`LMX_OP_XOR_LIT: begin
				cmd_ok = cmd_ok & ~cmd_dest;
			end
			default: begin
				cmd_ok = 1'b0;
			end
		endcase
		// command needs its two low byte lanes
		cmd_ok = cmd_ok & (wstrb[1:0] == 2'h3);
	end

	// shared result path
	lmx_alu u_alu (
		.op     (cmd_op),
		.acc    (q.acc),
		.lit    (cmd_lit),
		.fval   (q.file[cmd_faddr]),
		.result (alu_result),
		.zero   (alu_zero)
	);

	// next-state logic for the whole block
	always_comb begin
		d = q;

		// ready strobes last one cycle each
		d.awready = 1'b0;
		d.wready  = 1'b0;
		d.arready = 1'b0;

		// responses stand until the master takes them
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end

		// address and data are taken together, and only with no response pending,
		// which keeps one write in flight and costs one idle cycle per access
		if (!q.awready && !q.bvalid && awvalid && wvalid) begin
			d.awready = 1'b1;
			d.wready  = 1'b1;
		end
		if (!q.arready && !q.rvalid && arvalid) begin
			d.arready = 1'b1;
		end

		// status clear by writing one; a set later in this block wins
		if (wr_fire && wr_off == `LMX_OFS_STATUS && wstrb[0] && wdata[`LMX_ST_ENC_ERR]) begin
			d.enc_err = 1'b0;
		end

		// write decode
		if (wr_fire) begin
			d.bvalid = 1'b1;
			d.bresp  = `LMX_RESP_OKAY;
			case (wr_off)
				`LMX_OFS_CMD: begin
					if (!cmd_ok) begin
						d.enc_err = 1'b1;
						d.bresp   = `LMX_RESP_SLVERR;
					end else begin
						// each command retires on the edge that takes it
						case (cmd_op)
							`LMX_OP_LOAD_UPPER: begin
								d.pclatch = cmd_faddr;
							end
							`LMX_OP_LOAD_ACC: begin
								d.acc = cmd_lit;
							end
							`LMX_OP_STORE_ACC: begin
								d.file[cmd_faddr] = q.acc;
							end
							`LMX_OP_NIBBLE_X: begin
								if (cmd_dest) begin
									d.file[cmd_faddr] = alu_result;
								end else begin
									d.acc = alu_result;
								end
							end
							`LMX_OP_XOR_LIT: begin
								d.acc  = alu_result;
								d.zero = alu_zero;
							end
							default: begin
								d.bresp = `LMX_RESP_SLVERR;
							end
						endcase
					end
				end
				`LMX_OFS_ACC,
				`LMX_OFS_PCLATCH,
				`LMX_OFS_STATUS: begin
					// read-only state; status clear handled above
				end
				`LMX_OFS_FADDR: begin
					if (wstrb[0]) begin
						d.faddr = wdata[6:0];
					end
				end
				`LMX_OFS_FDATA: begin
					if (wstrb[0]) begin
						d.file[q.faddr] = wdata[7:0];
					end
				end
				default: begin
					d.bresp = `LMX_RESP_SLVERR;
				end
			endcase
		end

		// read decode; narrow values sit in the low bits
		if (rd_fire) begin
			d.rvalid = 1'b1;
			d.rresp  = `LMX_RESP_OKAY;
			case (rd_off)
				`LMX_OFS_CMD: begin
					d.rdata = 32'h00000000;
				end
				`LMX_OFS_ACC: begin
					d.rdata = {24'h000000, q.acc};
				end
				`LMX_OFS_PCLATCH: begin
					d.rdata = {25'h0000000, q.pclatch};
				end
				`LMX_OFS_STATUS: begin
					d.rdata = {30'h00000000, q.enc_err, q.zero};
				end
				`LMX_OFS_FADDR: begin
					d.rdata = {25'h0000000, q.faddr};
				end
				`LMX_OFS_FDATA: begin
					d.rdata = {24'h000000, q.file[q.faddr]};
				end
				default: begin
					d.rdata = 32'h00000000;
					d.rresp = `LMX_RESP_SLVERR;
				end
			endcase
		end
	end

	// single state register; synchronous reset to constants
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q.acc     <= `LMX_RST_ACC;
			q.pclatch <= `LMX_RST_PCLATCH;
			q.zero    <= 1'b0;
			q.enc_err <= 1'b0;
			q.faddr   <= `LMX_RST_FADDR;
			q.file    <= {128{`LMX_RST_FILE}};
			q.awready <= 1'b0;
			q.wready  <= 1'b0;
			q.bvalid  <= 1'b0;
			q.bresp   <= `LMX_RESP_OKAY;
			q.arready <= 1'b0;
			q.rvalid  <= 1'b0;
			q.rdata   <= 32'h00000000;
			q.rresp   <= `LMX_RESP_OKAY;
		end else begin
			q <= d;
		end
	end

	// every output is a field of the state register
	assign awready     = q.awready;
	assign wready      = q.wready;
	assign bvalid      = q.bvalid;
	assign bresp       = q.bresp;
	assign arready     = q.arready;
	assign rvalid      = q.rvalid;
	assign rdata       = q.rdata;
	assign rresp       = q.rresp;
	assign acc_out     = q.acc;
	assign pclatch_out = q.pclatch;
	assign zero_out    = q.zero;
endmodule

/* File: rtl/lmx_map.svh */
// register offsets, field positions, reset values and op codes of the literal/move/swap/xor datapath
`ifndef LMX_MAP_SVH
`define LMX_MAP_SVH

// register byte offsets on the axi4-lite slave
`define LMX_OFS_CMD       8'h00
`define LMX_OFS_ACC       8'h04
`define LMX_OFS_PCLATCH   8'h08
`define LMX_OFS_STATUS    8'h0c
`define LMX_OFS_FADDR     8'h10
`define LMX_OFS_FDATA     8'h14

// command word layout
`define LMX_CMD_LIT_MSB   7
`define LMX_CMD_LIT_LSB   0
`define LMX_CMD_TOP7      7
`define LMX_CMD_DEST      8
`define LMX_CMD_OP_MSB    11
`define LMX_CMD_OP_LSB    9
`define LMX_CMD_HI_MSB    31
`define LMX_CMD_HI_LSB    12

// status register fields
`define LMX_ST_ZERO       0
`define LMX_ST_ENC_ERR    1

// operation codes in the command word
`define LMX_OP_LOAD_UPPER 3'h0
`define LMX_OP_LOAD_ACC   3'h1
`define LMX_OP_STORE_ACC  3'h2
`define LMX_OP_NIBBLE_X   3'h3
`define LMX_OP_XOR_LIT    3'h4

// reset values
`define LMX_RST_ACC       8'h00
`define LMX_RST_PCLATCH   7'h00
`define LMX_RST_FADDR     7'h00
`define LMX_RST_FILE      8'h00

// axi responses
`define LMX_RESP_OKAY     2'h0
`define LMX_RESP_SLVERR   2'h2

`endif

/* File: rtl/lmx_pkg.sv */
// types shared by the literal/move/swap/xor datapath
package lmx_pkg;
`include "lmx_map.svh"

	typedef enum logic [2:0] {
		LMX_LOAD_UPPER = `LMX_OP_LOAD_UPPER,
		LMX_LOAD_ACC   = `LMX_OP_LOAD_ACC,
		LMX_STORE_ACC  = `LMX_OP_STORE_ACC,
		LMX_NIBBLE_X   = `LMX_OP_NIBBLE_X,
		LMX_XOR_LIT    = `LMX_OP_XOR_LIT
	} lmx_op_e;

	typedef struct packed {
		logic [7:0]        acc;
		logic [6:0]        pclatch;
		logic              zero;
		logic              enc_err;
		logic [6:0]        faddr;
		logic [127:0][7:0] file;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} lmx_state_s;
endpackage

/* File: verification/literal_move_swap_xor_ops_test.sv */
// self-checking bench of lmx_core driven over axi4-lite
`include "lmx_map.svh"
module literal_move_swap_xor_ops_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [2:0]  awprot = 0, arprot = 0;
	logic [3:0]  wstrb = 4'hf;
	logic [31:0] wdata = 0, rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, zero_out;
	logic [7:0]  acc_out;
	logic [6:0]  pclatch_out;
	int          error_cnt = 0, tests_run = 0;
	lmx_core dut (.*);
	// 50 ns period
	always #25 aclk = ~aclk;
	task give_verdict;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	function logic [31:0] cw(input logic [2:0] o, input logic d, input logic [7:0] l);
		return {20'h0, o, d, l};
	endfunction
	function logic [7:0] sw(input logic [7:0] v);
		return {v[3:0], v[7:4]};
	endfunction
	// outputs are read right after the edge, before its updates land
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin @(posedge aclk); n++; end while (!(awready === 1'b1 && wready === 1'b1) && n < 99);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 99);
		bready <= 1'b0;
		if (n >= 99) begin
			error_cnt++;
			give_verdict;
		end else begin
			chk("bresp", er, bresp);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 99);
		arvalid <= 1'b0;
		do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 99);
		rready <= 1'b0;
		if (n >= 99) begin
			error_cnt++;
			give_verdict;
		end else begin
			chk("rdata", e, rdata);
			chk("rresp", er, rresp);
		end
	endtask
	// main sequence: reset, then one command after another
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		chk("acc", 8'h00, acc_out);
		rd(`LMX_OFS_STATUS, 32'h0);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_LOAD_ACC, 0, 8'hff));
		chk("acc", 8'hff, acc_out);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_XOR_LIT, 0, 8'hff));
		chk("acc", 8'hff ^ 8'hff, acc_out);
		chk("zero", 1'b1, zero_out);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_LOAD_ACC, 0, 8'h5a));
		chk("zero", 1'b1, zero_out);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_LOAD_UPPER, 0, 8'h7f));
		chk("latch", 7'h7f, pclatch_out);
		chk("zero", 1'b1, zero_out);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_LOAD_UPPER, 0, 8'h80), `LMX_RESP_SLVERR);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_LOAD_ACC, 0, 8'h01) | 32'h1000, `LMX_RESP_SLVERR);
		chk("latch", 7'h7f, pclatch_out);
		chk("acc", 8'h5a, acc_out);
		rd(`LMX_OFS_STATUS, 32'h3);
		wr(`LMX_OFS_STATUS, 32'h2);
		rd(`LMX_OFS_STATUS, 32'h1);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_STORE_ACC, 0, 8'h7f));
		wr(`LMX_OFS_FADDR, 32'h7f);
		rd(`LMX_OFS_FDATA, 32'h5a);
		chk("zero", 1'b1, zero_out);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_NIBBLE_X, 1, 8'h7f));
		rd(`LMX_OFS_FDATA, sw(8'h5a));
		wr(`LMX_OFS_CMD, cw(`LMX_OP_LOAD_ACC, 0, 8'h11));
		wr(`LMX_OFS_CMD, cw(`LMX_OP_NIBBLE_X, 0, 8'h7f));
		chk("acc", sw(sw(8'h5a)), acc_out);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_XOR_LIT, 0, 8'h0f));
		chk("acc", 8'h5a ^ 8'h0f, acc_out);
		chk("zero", 1'b0, zero_out);
		rd(`LMX_OFS_ACC, 32'h55);
		rd(`LMX_OFS_PCLATCH, 32'h7f);
		// refused encodings: unknown op, stray destination bit, wide address, missing lane
		wr(`LMX_OFS_CMD, cw(3'h5, 0, 8'h00), `LMX_RESP_SLVERR);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_LOAD_ACC, 1, 8'h00), `LMX_RESP_SLVERR);
		wr(`LMX_OFS_CMD, cw(`LMX_OP_STORE_ACC, 0, 8'hff), `LMX_RESP_SLVERR);
		wstrb <= 4'h1;
		wr(`LMX_OFS_CMD, cw(`LMX_OP_LOAD_ACC, 0, 8'h00), `LMX_RESP_SLVERR);
		wstrb <= 4'hf;
		chk("acc", 8'h55, acc_out);
		rd(`LMX_OFS_STATUS, 32'h2);
		// read-only and write-only offsets answer okay and change nothing; unmapped offset 0x18 answers slverr
		wr(`LMX_OFS_ACC, 32'h0);
		rd(`LMX_OFS_ACC, 32'h55);
		rd(`LMX_OFS_CMD, 32'h0);
		rd(8'h18, 32'h0, `LMX_RESP_SLVERR);
		wr(8'h18, 32'h1, `LMX_RESP_SLVERR);
		give_verdict;
	end
endmodule

/* File: verification/lmx_asserts.sv */
// checker of handshake timing and datapath results of lmx_core
`include "lmx_map.svh"
module lmx_asserts #(
	parameter int ADDR_W = 8
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [31:0]       wdata,
	input wire logic [3:0]        wstrb,
	input wire logic              awready,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic              arready,
	input wire logic              rvalid,
	input wire logic              rready,
	input wire logic [7:0]        acc_out,
	input wire logic [6:0]        pclatch_out,
	input wire logic              zero_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// a command is taken when the write address pulse hits offset zero;
	// a word without both low byte lanes is refused, so it must not count as a load
	logic cmd;
	logic lanes_ok;
	assign cmd      = awready && awaddr == '0;
	assign lanes_ok = wstrb[1:0] == 2'h3;
	pair_ack_a: assert property (awready |-> wready) else $error("write readies split");
	resp_next_a: assert property (awready |=> bvalid && !awready) else $error("late write response");
	b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("write response dropped");
	r_next_a: assert property (arready |=> rvalid) else $error("late read data");
	r_hold_a: assert property (rvalid && !rready |=> rvalid) else $error("read data dropped");
	acc_load_a: assert property (cmd && lanes_ok && wdata[31:8] == 24'h000002 |=>
		acc_out == $past(wdata[7:0]) && $stable(zero_out)) else $error("literal load wrong");
	upper_load_a: assert property (cmd && lanes_ok && wdata[31:7] == 25'h0 |=>
		pclatch_out == $past(wdata[6:0]) && $stable(zero_out)) else $error("latch load wrong");
	xor_lit_a: assert property (cmd && lanes_ok && wdata[31:8] == 24'h000008 |=>
		acc_out == ($past(acc_out) ^ $past(wdata[7:0])) && zero_out == (acc_out == 8'h00))
		else $error("xor result wrong");
	zero_keep_a: assert property (!(cmd && wdata[11:9] == 3'h4) |=> $stable(zero_out))
		else $error("zero moved");
	latch_keep_a: assert property (!cmd |=> $stable(pclatch_out)) else $error("latch moved");
	acc_keep_a: assert property (!cmd |=> $stable(acc_out)) else $error("accumulator moved");
	high_bits_a: assert property (cmd && wdata[31:12] != 20'h00000 |=>
		bvalid && bresp == `LMX_RESP_SLVERR) else $error("unused bits accepted");
endmodule

bind lmx_core lmx_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);
